/* File: hw/lcdac_pkg.sv */
package lcdac_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int RAM_DEPTH = 128;
    localparam int ROWS = 32;
    localparam int COLS = 60;
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam logic [6:0] L1_END = 7'h4F;
    localparam logic [5:0] L2_END = 6'h27;
    localparam logic [4:0] L4_END = 5'h13;
    localparam logic [4:0] L4_START = 5'h00;
    localparam logic [5:0] L2_START = 6'h00;
    localparam logic [6:0] LEN_ONE = 7'h50;
    localparam logic [6:0] LEN_TWO = 7'h28;
    localparam logic [6:0] LEN_FOUR = 7'h14;
    localparam logic [3:0] GLYPH_RAM_COL = 4'h0;
    localparam int INS_DDA_BIT = 7;
    localparam int INS_CGA_BIT = 6;
    localparam int INS_FUNC_BIT = 5;
    localparam int INS_SHIFT_BIT = 4;
    localparam int INS_ENTRY_BIT = 2;
    localparam int FUNC_DL_BIT = 4;
    localparam int FUNC_N_BIT = 3;
    localparam int FUNC_M_BIT = 2;
    localparam int SHIFT_SC_BIT = 3;
    localparam int SHIFT_RL_BIT = 2;
    localparam int ENTRY_ID_BIT = 1;
    localparam int BUSY_TIME_NS = 40000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FRAME_DIV = 2304;
    localparam logic [7:0] ROW_TICKS_ONE = 8'h90;
    localparam logic [7:0] ROW_TICKS_MULTI = 8'h48;
    localparam logic [4:0] ROW_LAST_ONE = 5'h0F;
    localparam logic [4:0] ROW_LAST_MULTI = 5'h1F;

    typedef enum logic [1:0] {
        LINES_ONE = 2'b00,
        LINES_TWO = 2'b01,
        LINES_FOUR = 2'b10
    } lcdac_lines_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACTIVE = 2'b01
    } lcdac_bus_st_t;

    typedef struct packed {
        logic strobe;
        logic sel;
        logic rd;
        logic [7:0] data;
    } lcdac_bus_t;
endpackage

/* File: hw/lcdac_sync.sv */
`timescale 1ns/1ps
module lcdac_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: hw/lcdac_step.sv */
`timescale 1ns/1ps
module lcdac_step import lcdac_pkg::*; (
    input wire logic [6:0] addr,
    input wire logic up,
    input wire logic glyph,
    input wire lcdac_lines_t lines,
    output logic [6:0] next_addr
);
    always_comb begin
        next_addr = up ? addr + 7'h01 : addr - 7'h01;
        if (!glyph) begin
            case (lines)
                LINES_ONE: begin
                    if (up && addr == L1_END) next_addr = PTR_RST;
                    if (!up && addr == PTR_RST) next_addr = L1_END;
                end
                LINES_TWO: begin
                    if (up && addr[5:0] == L2_END) next_addr = {~addr[6], L2_START};
                    if (!up && addr[5:0] == L2_START) next_addr = {~addr[6], L2_END};
                end
                LINES_FOUR: begin
                    if (up && addr[4:0] == L4_END) begin
                        next_addr = {addr[6:5] + 2'h1, L4_START};
                    end
                    if (!up && addr[4:0] == L4_START) begin
                        next_addr = {addr[6:5] - 2'h1, L4_END};
                    end
                end
                default: ;
            endcase
        end
    end
endmodule

/* File: hw/lcdac_core.sv */
`timescale 1ns/1ps
module lcdac_core import lcdac_pkg::*; #(
    parameter int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic strobe_pin,
    input wire logic target_select_line,
    input wire logic read_line,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe,
    input wire logic osc_in,
    input wire logic [1:0] disp_line,
    input wire logic [6:0] disp_col,
    input wire logic [2:0] disp_glyph_row,
    output logic [7:0] disp_code,
    output logic disp_glyph_ram_sel,
    output logic [10:0] disp_glyph_rom_addr,
    output logic [7:0] disp_glyph_ram_data,
    output logic disp_cursor,
    input wire logic [59:0] col_pattern,
    output logic [31:0] row_out,
    output logic [59:0] col_out
);
    lcdac_bus_t pins_raw;
    lcdac_bus_t bus_s;
    logic osc_s;
    logic strobe_d;
    logic osc_d;

    assign pins_raw = '{strobe: strobe_pin, sel: target_select_line, rd: read_line,
                        data: data_in};

    lcdac_sync #(.W($bits(lcdac_bus_t) + 1)) u_sync (.mclk(mclk), .reset_n(reset_n),
        .d({pins_raw, osc_in}), .q({bus_s, osc_s}));

    // host side state
    lcdac_bus_st_t bus_st, next_bus_st;
    logic acc_sel, next_acc_sel;
    logic acc_rd, next_acc_rd;
    logic [6:0] address_pointer, next_address_pointer;
    logic glyph_sel, next_glyph_sel;
    logic up_dir, next_up_dir;
    lcdac_lines_t lines, next_lines;
    logic bus4, next_bus4;
    logic nib_low, next_nib_low;
    logic [3:0] hi_nib, next_hi_nib;
    logic [6:0] shift_amt, next_shift_amt;
    logic [7:0] instruction_code_register, next_instruction_code_register;
    logic [7:0] data_transfer_register, next_data_transfer_register;
    logic prefetch, next_prefetch;
    logic [15:0] busy_cnt, next_busy_cnt;
    logic busy;
    logic [7:0] next_data_out;
    logic drv, next_drv;
    logic rise, fall;
    logic [7:0] full, rd_val;
    logic ins_take, dat_write, dat_read;
    logic [6:0] step_addr, shift_next;
    logic [7:0] char_ram [RAM_DEPTH];
    logic [7:0] glyph_ram [RAM_DEPTH];

    assign busy = busy_cnt != 16'h0000;
    assign rise = bus_s.strobe && !strobe_d;
    assign fall = !bus_s.strobe && strobe_d;

    lcdac_step u_step (.addr(address_pointer), .up(up_dir), .glyph(glyph_sel), .lines(lines),
        .next_addr(step_addr));

    always_comb begin
        next_bus_st = bus_st;
        next_acc_sel = acc_sel;
        next_acc_rd = acc_rd;
        next_address_pointer = address_pointer;
        next_glyph_sel = glyph_sel;
        next_up_dir = up_dir;
        next_lines = lines;
        next_bus4 = bus4;
        next_nib_low = nib_low;
        next_hi_nib = hi_nib;
        next_shift_amt = shift_amt;
        next_instruction_code_register = instruction_code_register;
        next_data_transfer_register = data_transfer_register;
        next_prefetch = 1'b0;
        next_busy_cnt = busy ? busy_cnt - 16'h0001 : busy_cnt;
        next_data_out = data_out;
        next_drv = drv;
        ins_take = 1'b0;
        dat_write = 1'b0;
        dat_read = 1'b0;
        full = bus4 ? {hi_nib, bus_s.data[7:4]} : bus_s.data;
        shift_next = full[SHIFT_RL_BIT] ? shift_amt + 7'h01 : shift_amt - 7'h01;
        // status read returns busy and pointer, never the instruction register
        rd_val = acc_sel ? data_transfer_register : {busy, address_pointer};
        if (prefetch) begin
            next_data_transfer_register = glyph_sel ? glyph_ram[address_pointer]
                                                    : char_ram[address_pointer];
        end
        case (bus_st)
            BUS_IDLE: begin
                if (rise) begin
                    next_bus_st = BUS_ACTIVE;
                    next_acc_sel = bus_s.sel;
                    next_acc_rd = bus_s.rd;
                    next_drv = bus_s.rd;
                    rd_val = bus_s.sel ? data_transfer_register : {busy, address_pointer};
                    if (bus4) begin
                        next_data_out = nib_low ? {rd_val[3:0], 4'h0} : {rd_val[7:4], 4'h0};
                    end else begin
                        next_data_out = rd_val;
                    end
                end
            end
            BUS_ACTIVE: begin
                if (fall) begin
                    next_bus_st = BUS_IDLE;
                    next_drv = 1'b0;
                    next_nib_low = bus4 ? !nib_low : 1'b0;
                    if (!acc_rd && bus4 && !nib_low) begin
                        next_hi_nib = bus_s.data[7:4];
                    end
                    if (!bus4 || nib_low) begin
                        ins_take = !acc_rd && !acc_sel && !busy;
                        dat_write = !acc_rd && acc_sel;
                        dat_read = acc_rd && acc_sel;
                    end
                end
            end
            default: next_bus_st = BUS_IDLE;
        endcase
        if (dat_write || dat_read) begin
            next_address_pointer = step_addr;
            next_prefetch = 1'b1;
        end
        if (ins_take) begin
            next_instruction_code_register = full;
            next_busy_cnt = BUSY_CYCLES[15:0];
            if (full[INS_DDA_BIT]) begin
                next_address_pointer = full[6:0];
                next_glyph_sel = 1'b0;
                next_prefetch = 1'b1;
            end else if (full[INS_CGA_BIT]) begin
                next_address_pointer = {1'b0, full[5:0]};
                next_glyph_sel = 1'b1;
                next_prefetch = 1'b1;
            end else if (full[INS_FUNC_BIT]) begin
                next_bus4 = !full[FUNC_DL_BIT];
                next_nib_low = 1'b0;
                if (!full[FUNC_N_BIT]) next_lines = LINES_ONE;
                else next_lines = full[FUNC_M_BIT] ? LINES_FOUR : LINES_TWO;
            end else if (full[INS_SHIFT_BIT]) begin
                if (full[SHIFT_SC_BIT]) begin
                    next_shift_amt = (shift_next == LEN_ONE) ? PTR_RST :
                                     (shift_next > LEN_ONE) ? LEN_ONE - 7'h01 : shift_next;
                end else begin
                    next_address_pointer = step_addr;
                    next_prefetch = 1'b1;
                end
            end else if (full[INS_ENTRY_BIT]) begin
                next_up_dir = full[ENTRY_ID_BIT];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bus_st <= BUS_IDLE;
            strobe_d <= 1'b0;
            acc_sel <= 1'b0;
            acc_rd <= 1'b0;
            address_pointer <= PTR_RST;
            glyph_sel <= 1'b0;
            up_dir <= 1'b1;
            lines <= LINES_ONE;
            bus4 <= 1'b0;
            nib_low <= 1'b0;
            hi_nib <= 4'h0;
            shift_amt <= PTR_RST;
            instruction_code_register <= 8'h00;
            data_transfer_register <= 8'h00;
            prefetch <= 1'b0;
            busy_cnt <= 16'h0000;
            data_out <= 8'h00;
            drv <= 1'b0;
        end else begin
            bus_st <= next_bus_st;
            strobe_d <= bus_s.strobe;
            acc_sel <= next_acc_sel;
            acc_rd <= next_acc_rd;
            address_pointer <= next_address_pointer;
            glyph_sel <= next_glyph_sel;
            up_dir <= next_up_dir;
            lines <= next_lines;
            bus4 <= next_bus4;
            nib_low <= next_nib_low;
            hi_nib <= next_hi_nib;
            shift_amt <= next_shift_amt;
            instruction_code_register <= next_instruction_code_register;
            data_transfer_register <= next_data_transfer_register;
            prefetch <= next_prefetch;
            busy_cnt <= next_busy_cnt;
            data_out <= next_data_out;
            drv <= next_drv;
        end
    end

    // lower lines stay released on a 4-bit bus
    assign data_oe = {{4{drv}}, {4{drv && !bus4}}};

    // memories have no reset; unused character locations serve as spare storage
    always_ff @(posedge mclk) begin
        if (dat_write && !glyph_sel) char_ram[address_pointer] <= full;
        if (dat_write && glyph_sel) glyph_ram[address_pointer] <= full;
    end

    // display fetch: separate read port, so host traffic never stalls it
    logic [6:0] line_len, line_base, disp_addr;
    logic [7:0] pos_sum;
    logic [7:0] next_disp_code;
    logic [2:0] row_q;

    always_comb begin
        case (lines)
            LINES_TWO: begin
                line_len = LEN_TWO;
                line_base = {disp_line[0], 6'h00};
            end
            LINES_FOUR: begin
                line_len = LEN_FOUR;
                line_base = {disp_line, 5'h00};
            end
            default: begin
                line_len = LEN_ONE;
                line_base = PTR_RST;
            end
        endcase
        pos_sum = {1'b0, disp_col} + {1'b0, shift_amt};
        // each line wraps on its own length; ten steps cover any column plus shift
        for (int k = 0; k < 10; k++)
            if (pos_sum >= {1'b0, line_len}) pos_sum = pos_sum - {1'b0, line_len};
        disp_addr = line_base + pos_sum[6:0];
        next_disp_code = char_ram[disp_addr];
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            disp_code <= 8'h00;
            disp_cursor <= 1'b0;
            row_q <= 3'h0;
            disp_glyph_ram_sel <= 1'b0;
            disp_glyph_rom_addr <= 11'h000;
            disp_glyph_ram_data <= 8'h00;
        end else begin
            disp_code <= next_disp_code;
            row_q <= disp_glyph_row;
            disp_cursor <= !glyph_sel && disp_addr == address_pointer;
            disp_glyph_ram_sel <= disp_code[7:4] == GLYPH_RAM_COL;
            disp_glyph_rom_addr <= {disp_code, row_q};
            disp_glyph_ram_data <= glyph_ram[{disp_code[3:0], row_q}];
        end
    end

    // row scan from the display oscillator, independent of the host bus
    logic osc_tick;
    logic [7:0] tick_cnt, next_tick_cnt;
    logic [4:0] row_idx, next_row_idx;
    logic [31:0] next_row_out;
    logic [59:0] next_col_out;
    logic [7:0] row_ticks;
    logic [4:0] row_last;

    assign osc_tick = osc_s && !osc_d;

    always_comb begin
        row_ticks = (lines == LINES_ONE) ? ROW_TICKS_ONE : ROW_TICKS_MULTI;
        row_last = (lines == LINES_ONE) ? ROW_LAST_ONE : ROW_LAST_MULTI;
        next_tick_cnt = tick_cnt;
        next_row_idx = row_idx;
        next_col_out = col_out;
        if (osc_tick) begin
            if (tick_cnt >= row_ticks - 8'h01) begin
                next_tick_cnt = 8'h00;
                next_row_idx = (row_idx >= row_last) ? 5'h00 : row_idx + 5'h01;
                next_col_out = col_pattern;
            end else begin
                next_tick_cnt = tick_cnt + 8'h01;
            end
        end
        next_row_out = 32'h0000_0001 << row_idx;
        if (lines == LINES_ONE) begin
            next_row_out = (32'h0000_0001 << row_idx[3:0]) |
                           (32'h0001_0000 << row_idx[3:0]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            osc_d <= 1'b0;
            tick_cnt <= 8'h00;
            row_idx <= 5'h00;
            row_out <= 32'h0000_0000;
            col_out <= 60'h0;
        end else begin
            osc_d <= osc_s;
            tick_cnt <= next_tick_cnt;
            row_idx <= next_row_idx;
            row_out <= next_row_out;
            col_out <= next_col_out;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_status_start;
        bus_st == BUS_IDLE && rise && !bus_s.sel && bus_s.rd && !bus4;
    endsequence
    sequence s_instr_accept;
        bus_st == BUS_ACTIVE && fall && !acc_rd && !acc_sel && !busy && !bus4;
    endsequence
    chk_busy_on_top: assert property (
        s_status_start |=> data_out[7] == $past(busy) && data_oe[7] == 1'b1)
        else $error("busy bit not on top data line");
    chk_pointer_on_low: assert property (
        s_status_start |=> data_out[6:0] == $past(address_pointer))
        else $error("pointer not on low data lines");
    chk_data_read_value: assert property (
        bus_st == BUS_IDLE && rise && bus_s.sel && bus_s.rd && !bus4
        |=> data_out == $past(data_transfer_register))
        else $error("data register not presented on read");
    chk_busy_holds: assert property (
        s_instr_accept |=> busy [*8])
        else $error("busy dropped too early after instruction");
    chk_instr_ignored: assert property (
        bus_st == BUS_ACTIVE && fall && !acc_rd && !acc_sel && busy && !bus4
        |=> $stable(instruction_code_register))
        else $error("instruction taken while busy");
    chk_one_line_wrap: assert property (
        dat_write && lines == LINES_ONE && up_dir && !glyph_sel && address_pointer == L1_END
        |=> address_pointer == PTR_RST ##1 prefetch == 1'b0)
        else $error("one-line wrap wrong");
    chk_four_line_jump: assert property (
        dat_write && lines == LINES_FOUR && up_dir && !glyph_sel &&
        address_pointer[4:0] == L4_END
        |=> address_pointer[4:0] == L4_START &&
            address_pointer[6:5] == $past(address_pointer[6:5]) + 2'h1)
        else $error("four-line jump wrong");
    chk_cursor_glyph: assert property (
        glyph_sel |=> !disp_cursor)
        else $error("cursor shown for glyph pointer");
    chk_row_pairs: assert property (
        lines == LINES_ONE ##1 lines == LINES_ONE |=> row_out[15:0] == row_out[31:16])
        else $error("row pairs differ in one-line mode");
    chk_prefetch_load: assert property (
        prefetch && !glyph_sel && !dat_write |=>
        data_transfer_register == char_ram[$past(address_pointer)])
        else $error("data register not loaded from RAM");
endmodule

/* File: tb/lcdac_host.sv */
`timescale 1ns/1ps
module lcdac_host import lcdac_pkg::*; (
    input wire logic mclk,
    input wire logic [7:0] dev_data,
    input wire logic [7:0] dev_oe,
    output lcdac_bus_t bus
);
    logic strobe;
    logic sel;
    logic rd;
    logic [7:0] host_d;
    logic [7:0] host_oe;
    logic [7:0] level;
    // undriven lines float high through the pull-ups
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = host_oe[i] ? host_d[i] : (dev_oe[i] ? dev_data[i] : 1'b1);
        end
    end
    assign bus = '{strobe: strobe, sel: sel, rd: rd, data: level};
    initial begin
        strobe = 1'b0;
        sel = 1'b0;
        rd = 1'b1;
        host_d = 8'h00;
        host_oe = 8'h00;
    end
    task automatic xfer(input logic s, input logic r, input logic [7:0] d,
                        input logic [7:0] lanes, output logic [7:0] q);
        @(posedge mclk);
        #1;
        sel = s;
        rd = r;
        host_d = d;
        host_oe = r ? 8'h00 : lanes;
        @(posedge mclk);
        #1;
        strobe = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        q = level;
        strobe = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        host_oe = 8'h00;
        repeat (4) @(posedge mclk);
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb_top import lcdac_pkg::*;;
    logic mclk;
    logic reset_n;
    logic osc_in;
    logic nib;
    logic [1:0] disp_line;
    logic [6:0] disp_col;
    logic [2:0] disp_glyph_row;
    logic [7:0] data_out;
    logic [7:0] data_oe;
    logic [7:0] disp_code;
    logic disp_glyph_ram_sel;
    logic [10:0] disp_glyph_rom_addr;
    logic [7:0] disp_glyph_ram_data;
    logic disp_cursor;
    logic [31:0] row_out;
    logic [59:0] col_out;
    localparam logic [59:0] COL_PAT = 60'h0F0F0F0F0F0F0F0;
    lcdac_bus_t bus;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] fn_tab [6] = '{8'h38, 8'h38, 8'h3C, 8'h3C, 8'h3C, 8'h3C};
    logic [6:0] from_tab [6] = '{7'h27, 7'h67, 7'h13, 7'h33, 7'h53, 7'h73};
    logic [6:0] to_tab [6] = '{7'h40, 7'h00, 7'h20, 7'h40, 7'h60, 7'h00};

    lcdac_host host (.mclk(mclk), .dev_data(data_out), .dev_oe(data_oe), .bus(bus));
    lcdac_core #(.BUSY_CYCLES(40)) DUT (.mclk(mclk), .reset_n(reset_n),
        .strobe_pin(bus.strobe), .target_select_line(bus.sel), .read_line(bus.rd),
        .data_in(bus.data), .data_out(data_out), .data_oe(data_oe), .osc_in(osc_in),
        .disp_line(disp_line), .disp_col(disp_col), .disp_glyph_row(disp_glyph_row),
        .disp_code(disp_code), .disp_glyph_ram_sel(disp_glyph_ram_sel),
        .disp_glyph_rom_addr(disp_glyph_rom_addr), .disp_glyph_ram_data(disp_glyph_ram_data),
        .disp_cursor(disp_cursor), .col_pattern(COL_PAT), .row_out(row_out),
        .col_out(col_out));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        osc_in = 1'b0;
        forever #80 osc_in = ~osc_in;
    end
    initial begin
        #400000;
        err_total++;
        complete_run();
    end

    task automatic complete_run();
        $display("checks_done %0d err_total %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic s, input logic r, input logic [7:0] d,
                       output logic [7:0] q);
        logic [7:0] q1;
        logic [7:0] q2;
        if (nib) begin
            host.xfer(s, r, {d[7:4], 4'h0}, 8'hF0, q1);
            host.xfer(s, r, {d[3:0], 4'h0}, 8'hF0, q2);
            q = {q1[7:4], q2[7:4]};
            if (r) `CHK(q1[3:0], 4'hF)
        end else begin
            host.xfer(s, r, d, 8'hFF, q);
        end
    endtask
    // polls status until idle, returns last status byte
    task automatic ready(output logic [7:0] q);
        int n;
        n = 0;
        acc(1'b0, 1'b1, 8'h00, q);
        while (q[7] !== 1'b0 && n < 40) begin
            n++;
            acc(1'b0, 1'b1, 8'h00, q);
        end
        if (q[7] !== 1'b0) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic ins(input logic [7:0] d);
        logic [7:0] q;
        ready(q);
        acc(1'b0, 1'b0, d, q);
    endtask
    task automatic fetch(input logic [1:0] ln, input logic [6:0] col, input logic [2:0] gr);
        @(posedge mclk);
        #1;
        disp_line = ln;
        disp_col = col;
        disp_glyph_row = gr;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    initial begin
        logic [7:0] q;
        logic [31:0] q_row;
        int n;
        reset_n = 1'b0;
        nib = 1'b0;
        disp_line = 2'h0;
        disp_col = 7'h00;
        disp_glyph_row = 3'h0;
        repeat (4) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        @(posedge mclk);
        #1;
        `CHK(row_out, 32'h00010001)
        acc(1'b0, 1'b1, 8'h00, q);
        `CHK(q, 8'h00)
        ins(8'hCE);
        acc(1'b0, 1'b1, 8'h00, q);
        `CHK(q, 8'hCE)
        acc(1'b0, 1'b0, 8'h90, q);
        ready(q);
        `CHK(q, 8'h4E)
        acc(1'b1, 1'b0, 8'h41, q);
        acc(1'b1, 1'b0, 8'h42, q);
        ready(q);
        `CHK(q, 8'h00)
        ins(8'h04);
        acc(1'b1, 1'b0, 8'h43, q);
        ready(q);
        `CHK(q, 8'h4F)
        ins(8'h06);
        for (int i = 0; i < 6; i++) begin
            ins(fn_tab[i]);
            ins({1'b1, from_tab[i]});
            acc(1'b1, 1'b0, 8'h30 + 8'(i), q);
            ready(q);
            `CHK(q, {1'b0, to_tab[i]})
        end
        ins(8'h93);
        ready(q);
        acc(1'b1, 1'b1, 8'h00, q);
        `CHK(q, 8'h32)
        ready(q);
        `CHK(q, 8'h20)
        fetch(2'h0, 7'h13, 3'h0);
        `CHK(disp_code, 8'h32)
        fetch(2'h3, 7'h13, 3'h0);
        `CHK(disp_code, 8'h35)
        // shift by one: column 0 of line one must show the end of its own range
        ins(8'h18);
        fetch(2'h0, 7'h00, 3'h0);
        `CHK(disp_code, 8'h32)
        ins(8'h1C);
        fetch(2'h1, 7'h00, 3'h0);
        `CHK(disp_cursor, 1'b1)
        ins(8'h45);
        ready(q);
        fetch(2'h1, 7'h00, 3'h0);
        `CHK(disp_cursor, 1'b0)
        acc(1'b1, 1'b0, 8'h1F, q);
        ins(8'hA0);
        acc(1'b1, 1'b0, 8'h00, q);
        fetch(2'h1, 7'h00, 3'h5);
        `CHK(disp_glyph_ram_sel, 1'b1)
        `CHK(disp_glyph_ram_data, 8'h1F)
        `CHK(disp_glyph_rom_addr, 11'h005)
        ins(8'h45);
        ready(q);
        acc(1'b1, 1'b1, 8'h00, q);
        `CHK(q, 8'h1F)
        ins(8'h2C);
        nib = 1'b1;
        ins(8'hA1);
        acc(1'b1, 1'b0, 8'h5A, q);
        ready(q);
        `CHK(q, 8'h22)
        ins(8'hA1);
        ready(q);
        acc(1'b1, 1'b1, 8'h00, q);
        `CHK(q, 8'h5A)
        // four-line mode: wait for the next row step, bounded
        #1;
        q_row = row_out;
        n = 0;
        while (row_out === q_row && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK(row_out, {q_row[30:0], q_row[31]})
        `CHK(col_out, COL_PAT)
        complete_run();
    end
endmodule
